// ==== tbf_pkg.sv ====
// shared constants and carrier types for the triple-port dual fifo
package tbf_pkg;

    // bus widths
    localparam int PORT_A_W     = 36;
    localparam int PORT_BC_W    = 18;
    localparam int BYTE_W       = 9;
    localparam int WORD_PARTS   = 2;
    localparam int BYTE_PARTS   = 4;

    // per-fifo capacity in long words and default partial-flag offset
    localparam int CAPACITY_DEF = 256;
    localparam int OFFSET_DEF   = 8;
    localparam int FIFO_DEPTH_DEF = 32;

    // flag reset values (fifos empty after reset)
    localparam logic ROOM_RST    = 1'b1;
    localparam logic AFULL_N_RST = 1'b1;
    localparam logic AEMPTY_N_RST = 1'b0;
    localparam logic READY_RST   = 1'b0;

    // pins of port a, sampled as one bundle
    typedef struct packed {
        logic                clk;
        logic                chipSelectN;
        logic                writeNotRead;
        logic                mailboxSelect;
        logic                enable;
        logic [PORT_A_W-1:0] data;
    } tbf_port_a_in_type;

    // pins of port b
    typedef struct packed {
        logic clk;
        logic chipSelectN;
        logic mailboxSelect;
        logic enable;
    } tbf_port_b_in_type;

    // pins of port c
    typedef struct packed {
        logic                 clk;
        logic                 mailboxSelect;
        logic                 enable;
        logic [PORT_BC_W-1:0] data;
    } tbf_port_c_in_type;

    // static configuration straps
    typedef struct packed {
        logic fallThroughMode;
        logic portBByteSize;
        logic portCByteSize;
    } tbf_cfg_type;

endpackage : tbf_pkg

// ==== tbf_sync.sv ====
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module tbf_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // bundle
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;

    // first stage feeds only the second stage
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= '0;
            syncOut    <= '0;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end

endmodule : tbf_sync

// ==== tbf_fifo.sv ====
// single-clock fifo with valid/ready on both sides
`timescale 1ns/10ps
module tbf_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = tbf_pkg::FIFO_DEPTH_DEF
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // drain side
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_reg;
    logic [AW:0]      rdPtr_reg;
    logic             push;
    logic             pop;

    assign inReady  = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_reg != rdPtr_reg;
    assign outData  = mem[rdPtr_reg[AW-1:0]];
    assign push     = inValid & inReady;
    assign pop      = outReady & outValid;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_reg + (AW+1)'(push);
            rdPtr_reg <= rdPtr_reg + (AW+1)'(pop);
        end
    end

endmodule : tbf_fifo

// ==== tbf_dual_fifo.sv ====
// triple-port dual fifo: flag resynchronisation, bus sizing and mailboxes
`timescale 1ns/10ps
module tbf_dual_fifo #(
    parameter int CAPACITY = tbf_pkg::CAPACITY_DEF,
    parameter int OFFSET   = tbf_pkg::OFFSET_DEF
) (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    // configuration straps
    input  wire tbf_pkg::tbf_cfg_type          cfgIn,
    // port a pins
    input  wire tbf_pkg::tbf_port_a_in_type    portAIn,
    output logic [tbf_pkg::PORT_A_W-1:0]       portADataOut,
    output logic                               portADataOe,
    output logic                               portAInputReady,
    output logic                               portAFullFlag,
    output logic                               portAAlmostFull,
    output logic                               portAAlmostEmpty,
    output logic                               portAOutputReady,
    // port b pins
    input  wire tbf_pkg::tbf_port_b_in_type    portBIn,
    output logic [tbf_pkg::PORT_BC_W-1:0]      portBDataOut,
    output logic                               portBDataOe,
    output logic                               portBAlmostEmpty,
    output logic                               portBOutputReady,
    // port c pins
    input  wire tbf_pkg::tbf_port_c_in_type    portCIn,
    output logic                               portCInputReady,
    output logic                               portCFullFlag,
    output logic                               portCAlmostFull
);

    localparam int AW = tbf_pkg::PORT_A_W;
    localparam int CW = tbf_pkg::PORT_BC_W;
    localparam int BW = tbf_pkg::BYTE_W;
    localparam int NW = $clog2(CAPACITY) + 1;
    localparam logic [NW-1:0] CAP_N   = NW'(CAPACITY);
    localparam logic [NW-1:0] AF_LIM  = NW'(CAPACITY - OFFSET);
    localparam logic [NW-1:0] AE_LIM  = NW'(OFFSET);

    // pick one part of a long word for port b
    function automatic logic [CW-1:0] pickPart(input logic [AW-1:0] lw,
                                               input logic [1:0]    part,
                                               input logic          byteMode);
        logic [CW-1:0] res;
        res = '0;
        if (byteMode) begin
            res[BW-1:0] = lw[part*BW +: BW];
        end else begin
            res = lw[part[0]*CW +: CW];
        end
        return res;
    endfunction : pickPart

    // is this the part that completes a long word
    function automatic logic lastPart(input logic [1:0] part,
                                      input logic       byteMode);
        return byteMode ? (part == 2'(tbf_pkg::BYTE_PARTS - 1))
                        : (part == 2'(tbf_pkg::WORD_PARTS - 1));
    endfunction : lastPart

    // sampled pins
    tbf_pkg::tbf_port_a_in_type aS;
    tbf_pkg::tbf_port_b_in_type bS;
    tbf_pkg::tbf_port_c_in_type cS;
    tbf_pkg::tbf_cfg_type       cfg;

    tbf_sync #(.WIDTH($bits(tbf_pkg::tbf_port_a_in_type))) syncA (
        .mclk(mclk), .rst_n(rst_n), .asyncIn(portAIn), .syncOut(aS));
    tbf_sync #(.WIDTH($bits(tbf_pkg::tbf_port_b_in_type))) syncB (
        .mclk(mclk), .rst_n(rst_n), .asyncIn(portBIn), .syncOut(bS));
    tbf_sync #(.WIDTH($bits(tbf_pkg::tbf_port_c_in_type))) syncC (
        .mclk(mclk), .rst_n(rst_n), .asyncIn(portCIn), .syncOut(cS));
    tbf_sync #(.WIDTH($bits(tbf_pkg::tbf_cfg_type))) syncCfg (
        .mclk(mclk), .rst_n(rst_n), .asyncIn(cfgIn), .syncOut(cfg));

    // port clock edges seen in the mclk domain
    logic aClkPrev_reg;
    logic bClkPrev_reg;
    logic cClkPrev_reg;
    logic aEdge;
    logic bEdge;
    logic cEdge;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aClkPrev_reg <= 1'b0;
            bClkPrev_reg <= 1'b0;
            cClkPrev_reg <= 1'b0;
        end else begin
            aClkPrev_reg <= aS.clk;
            bClkPrev_reg <= bS.clk;
            cClkPrev_reg <= cS.clk;
        end
    end

    assign aEdge = aS.clk & ~aClkPrev_reg;
    assign bEdge = bS.clk & ~bClkPrev_reg;
    assign cEdge = cS.clk & ~cClkPrev_reg;

    // flag state, also driven out
    logic roomA_reg;
    logic roomC_reg;
    logic readyA_reg;
    logic readyB_reg;

    // fifo handshakes
    logic          f1InReady;
    logic          f2InReady;
    logic [AW-1:0] f1Head;
    logic [AW-1:0] f2Head;
    logic          f1HeadValid;
    logic          f2HeadValid;

    // port a requests
    logic aWriteF1;
    logic aReadF2;
    logic aMailWrite;
    logic aMailRead;

    assign aWriteF1   = aEdge & ~aS.chipSelectN & aS.writeNotRead & ~aS.mailboxSelect
                        & aS.enable & roomA_reg & f1InReady;
    assign aReadF2    = aEdge & ~aS.chipSelectN & ~aS.writeNotRead & ~aS.mailboxSelect
                        & aS.enable & readyA_reg & f2HeadValid;
    assign aMailWrite = aEdge & ~aS.chipSelectN & aS.writeNotRead & aS.mailboxSelect
                        & aS.enable;
    assign aMailRead  = aEdge & ~aS.chipSelectN & ~aS.writeNotRead & aS.mailboxSelect
                        & aS.enable;

    // port b requests
    logic [1:0] bPart_reg;
    logic       bRead;
    logic       bPop;
    logic       bMailRead;

    assign bRead     = bEdge & ~bS.chipSelectN & ~bS.mailboxSelect & bS.enable
                       & readyB_reg & f1HeadValid;
    assign bPop      = bRead & lastPart(bPart_reg, cfg.portBByteSize);
    assign bMailRead = bEdge & ~bS.chipSelectN & bS.mailboxSelect & bS.enable;

    // port c requests
    logic [1:0]    cPart_reg;
    logic [AW-1:0] cLong_reg;
    logic [AW-1:0] cLongNext;
    logic          cWrite;
    logic          cPush;
    logic          cMailWrite;

    assign cWrite     = cEdge & ~cS.mailboxSelect & cS.enable & roomC_reg;
    assign cPush      = cWrite & lastPart(cPart_reg, cfg.portCByteSize) & f2InReady;
    assign cMailWrite = cEdge & cS.mailboxSelect & cS.enable;

    // little-endian placement: the first part written lands in the low bits
    always_comb begin
        cLongNext = cLong_reg;
        if (cfg.portCByteSize) begin
            cLongNext[cPart_reg*BW +: BW] = cS.data[BW-1:0];
        end else begin
            cLongNext[cPart_reg[0]*CW +: CW] = cS.data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cPart_reg <= '0;
            cLong_reg <= '0;
        end else if (cWrite) begin
            cLong_reg <= cLongNext;
            cPart_reg <= lastPart(cPart_reg, cfg.portCByteSize) ? 2'h0 : cPart_reg + 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bPart_reg <= '0;
        end else if (bRead) begin
            bPart_reg <= lastPart(bPart_reg, cfg.portBByteSize) ? 2'h0 : bPart_reg + 2'h1;
        end
    end

    // data storage; capacity sizes both fifos, so the flags never let them overflow
    tbf_fifo #(.WIDTH(AW), .DEPTH(CAPACITY)) fifo1 (
        .mclk(mclk), .rst_n(rst_n),
        .inData(aS.data), .inValid(aWriteF1), .inReady(f1InReady),
        .outData(f1Head), .outValid(f1HeadValid), .outReady(bPop));
    tbf_fifo #(.WIDTH(AW), .DEPTH(CAPACITY)) fifo2 (
        .mclk(mclk), .rst_n(rst_n),
        .inData(cLongNext), .inValid(cPush), .inReady(f2InReady),
        .outData(f2Head), .outValid(f2HeadValid), .outReady(aReadF2));

    // long-word counts on each side of each fifo
    logic [NW-1:0] f1Wr_reg;
    logic [NW-1:0] f1Rd_reg;
    logic [NW-1:0] f2Wr_reg;
    logic [NW-1:0] f2Rd_reg;
    logic [NW-1:0] f1WrNext;
    logic [NW-1:0] f1RdNext;
    logic [NW-1:0] f2WrNext;
    logic [NW-1:0] f2RdNext;

    assign f1WrNext = f1Wr_reg + NW'(aWriteF1);
    assign f1RdNext = f1Rd_reg + NW'(bPop);
    assign f2WrNext = f2Wr_reg + NW'(cPush);
    assign f2RdNext = f2Rd_reg + NW'(aReadF2);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            f1Wr_reg <= '0;
            f1Rd_reg <= '0;
            f2Wr_reg <= '0;
            f2Rd_reg <= '0;
        end else begin
            f1Wr_reg <= f1WrNext;
            f1Rd_reg <= f1RdNext;
            f2Wr_reg <= f2WrNext;
            f2Rd_reg <= f2RdNext;
        end
    end

    // far-side counts captured on the local port clock; the flag register is
    // the second stage, so a far event shows at the second local edge at best
    logic [NW-1:0] f1RdAtA_reg;
    logic [NW-1:0] f2WrAtA_reg;
    logic [NW-1:0] f1WrAtB_reg;
    logic [NW-1:0] f2RdAtC_reg;
    logic [NW-1:0] f1LevelA;
    logic [NW-1:0] f2LevelA;
    logic [NW-1:0] f1LevelB;
    logic [NW-1:0] f2LevelC;

    assign f1LevelA = f1WrNext - f1RdAtA_reg;
    assign f2LevelA = f2WrAtA_reg - f2RdNext;
    assign f1LevelB = f1WrAtB_reg - f1RdNext;
    assign f2LevelC = f2WrNext - f2RdAtC_reg;

    // port a flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            f1RdAtA_reg      <= '0;
            f2WrAtA_reg      <= '0;
            roomA_reg        <= tbf_pkg::ROOM_RST;
            readyA_reg       <= tbf_pkg::READY_RST;
            portAInputReady  <= 1'b0;
            portAFullFlag    <= 1'b0;
            portAAlmostFull  <= tbf_pkg::AFULL_N_RST;
            portAAlmostEmpty <= tbf_pkg::AEMPTY_N_RST;
            portAOutputReady <= tbf_pkg::READY_RST;
        end else if (aEdge) begin
            f1RdAtA_reg      <= f1Rd_reg;
            f2WrAtA_reg      <= f2Wr_reg;
            roomA_reg        <= f1LevelA < CAP_N;
            portAInputReady  <= cfg.fallThroughMode & (f1LevelA < CAP_N);
            portAFullFlag    <= ~cfg.fallThroughMode & (f1LevelA < CAP_N);
            portAAlmostFull  <= f1LevelA < AF_LIM;
            portAAlmostEmpty <= f2LevelA > AE_LIM;
            readyA_reg       <= f2LevelA != '0;
            portAOutputReady <= f2LevelA != '0;
        end
    end

    // port b flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            f1WrAtB_reg      <= '0;
            readyB_reg       <= tbf_pkg::READY_RST;
            portBAlmostEmpty <= tbf_pkg::AEMPTY_N_RST;
            portBOutputReady <= tbf_pkg::READY_RST;
        end else if (bEdge) begin
            f1WrAtB_reg      <= f1Wr_reg;
            portBAlmostEmpty <= f1LevelB > AE_LIM;
            readyB_reg       <= f1LevelB != '0;
            portBOutputReady <= f1LevelB != '0;
        end
    end

    // port c flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            f2RdAtC_reg     <= '0;
            roomC_reg       <= tbf_pkg::ROOM_RST;
            portCInputReady <= 1'b0;
            portCFullFlag   <= 1'b0;
            portCAlmostFull <= tbf_pkg::AFULL_N_RST;
        end else if (cEdge) begin
            f2RdAtC_reg     <= f2Rd_reg;
            roomC_reg       <= f2LevelC < CAP_N;
            portCInputReady <= cfg.fallThroughMode & (f2LevelC < CAP_N);
            portCFullFlag   <= ~cfg.fallThroughMode & (f2LevelC < CAP_N);
            portCAlmostFull <= f2LevelC < AF_LIM;
        end
    end

    // mailboxes; unused upper bits are held at zero rather than left floating
    logic [CW-1:0] aToBMail_reg;
    logic [CW-1:0] cToAMail_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aToBMail_reg <= '0;
        end else if (aMailWrite) begin
            if (cfg.portBByteSize) begin
                aToBMail_reg <= {{(CW-BW){1'b0}}, aS.data[BW-1:0]};
            end else begin
                aToBMail_reg <= aS.data[CW-1:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cToAMail_reg <= '0;
        end else if (cMailWrite) begin
            if (cfg.portCByteSize) begin
                cToAMail_reg <= {{(CW-BW){1'b0}}, cS.data[BW-1:0]};
            end else begin
                cToAMail_reg <= cS.data;
            end
        end
    end

    // port a output bus
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            portADataOut <= '0;
            portADataOe  <= 1'b0;
        end else begin
            portADataOe <= ~aS.chipSelectN & ~aS.writeNotRead;
            if (aReadF2) begin
                portADataOut <= f2Head;
            end else if (aMailRead) begin
                portADataOut <= {cToAMail_reg, {CW{1'b0}}};
            end
        end
    end

    // port b output bus
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            portBDataOut <= '0;
            portBDataOe  <= 1'b0;
        end else begin
            portBDataOe <= ~bS.chipSelectN;
            if (bRead) begin
                portBDataOut <= pickPart(f1Head, bPart_reg, cfg.portBByteSize);
            end else if (bMailRead) begin
                portBDataOut <= aToBMail_reg;
            end
        end
    end

endmodule : tbf_dual_fifo

// ==== tbf_dual_fifo_monitor.sv ====
// assertion checker for dual fifo flag timing and bus sizing
`timescale 1ns/10ps
module tbf_dual_fifo_monitor (
    // clock, reset and straps
    input wire logic                           mclk,
    input wire logic                           rst_n,
    input wire tbf_pkg::tbf_cfg_type           cfgIn,
    // port pins
    input wire tbf_pkg::tbf_port_a_in_type     portAIn,
    input wire tbf_pkg::tbf_port_b_in_type     portBIn,
    input wire tbf_pkg::tbf_port_c_in_type     portCIn,
    // flags and data
    input wire logic                           portAInputReady,
    input wire logic                           portAFullFlag,
    input wire logic                           portAAlmostFull,
    input wire logic                           portAAlmostEmpty,
    input wire logic [tbf_pkg::PORT_BC_W-1:0]  portBDataOut,
    input wire logic                           portBAlmostEmpty,
    input wire logic                           portBOutputReady,
    input wire logic                           portCInputReady,
    input wire logic                           portCFullFlag,
    input wire logic                           portCAlmostFull
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [2:0] clkD;
    logic [3:0] aAge;
    logic [3:0] bAge;
    logic [3:0] cAge;
    // cleared like the design's sync stages: a clock high at release counts as an edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clkD <= 3'h0;
        end else begin
            clkD <= {portAIn.clk, portBIn.clk, portCIn.clk};
        end
    end
    // mclk cycles since each port clock last rose, saturating
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aAge <= 4'hF;
            bAge <= 4'hF;
            cAge <= 4'hF;
        end else begin
            aAge <= (portAIn.clk && !clkD[2]) ? 4'h0 : aAge + {3'h0, aAge != 4'hF};
            bAge <= (portBIn.clk && !clkD[1]) ? 4'h0 : bAge + {3'h0, bAge != 4'hF};
            cAge <= (portCIn.clk && !clkD[0]) ? 4'h0 : cAge + {3'h0, cAge != 4'hF};
        end
    end
    sequence s_c_filled;
        $fell(portCFullFlag);
    endsequence
    sequence s_a_filled;
        $fell(portAFullFlag);
    endsequence
    a_std_ready_low: assert property (!cfgIn.fallThroughMode && $past(rst_n, 6)
        |-> !portAInputReady && !portCInputReady) else $error("ready set in standard mode");
    a_fall_through_mode_full_low: assert property (cfgIn.fallThroughMode && $past(rst_n, 6)
        |-> !portAFullFlag && !portCFullFlag) else $error("full flag set in fall_through_mode mode");
    a_byte_top_zero: assert property (cfgIn.portBByteSize && $past(rst_n, 6)
        |-> portBDataOut[17:9] == 9'h000) else $error("upper port b bits not zero");
    a_b_ae_edge: assert property ($changed(portBAlmostEmpty) |-> bAge inside {[2:6]})
        else $error("port b almost-empty moved off a port b edge");
    a_a_ae_edge: assert property ($changed(portAAlmostEmpty) |-> aAge inside {[2:6]})
        else $error("port a almost-empty moved off a port a edge");
    a_a_full_edge: assert property ($changed(portAFullFlag) |-> aAge inside {[2:6]})
        else $error("port a full flag moved off a port a edge");
    a_c_full_edge: assert property ($changed(portCFullFlag) |-> cAge inside {[2:6]})
        else $error("port c full flag moved off a port c edge");
    a_b_ae_ready: assert property (portBAlmostEmpty |-> portBOutputReady)
        else $error("port b not almost empty yet empty");
    a_c_full_af: assert property (s_c_filled |-> !portCAlmostFull)
        else $error("port c full without almost-full");
    a_a_full_af: assert property (s_a_filled |-> !portAAlmostFull)
        else $error("port a full without almost-full");
endmodule : tbf_dual_fifo_monitor

bind tbf_dual_fifo tbf_dual_fifo_monitor i_mon (.mclk(mclk), .rst_n(rst_n), .cfgIn(cfgIn),
    .portAIn(portAIn), .portBIn(portBIn), .portCIn(portCIn),
    .portAInputReady(portAInputReady), .portAFullFlag(portAFullFlag),
    .portAAlmostFull(portAAlmostFull), .portAAlmostEmpty(portAAlmostEmpty),
    .portBDataOut(portBDataOut), .portBAlmostEmpty(portBAlmostEmpty),
    .portBOutputReady(portBOutputReady), .portCInputReady(portCInputReady),
    .portCFullFlag(portCFullFlag), .portCAlmostFull(portCAlmostFull));

// ==== tbf_host_model.sv ====
// host model for the three port buses with free-running port clocks
`timescale 1ns/10ps
module tbf_host_model (
    // port pins
    output tbf_pkg::tbf_port_a_in_type pa,
    output tbf_pkg::tbf_port_b_in_type pb,
    output tbf_pkg::tbf_port_c_in_type pc
);
    // clocks start off the mclk edges so sampling never races
    initial begin
        pa = '0;
        pb = '0;
        pc = '0;
        pa.chipSelectN = 1'b1;
        pb.chipSelectN = 1'b1;
        #2;
        fork
            forever #25 pa.clk = ~pa.clk;
            forever #30 pb.clk = ~pb.clk;
            forever #35 pc.clk = ~pc.clk;
        join
    end
    // each operation holds its pins over one port edge; released data lines toggle
    task automatic aOp(input logic wr, input logic mb, input logic [35:0] d);
        @(posedge pa.clk) #1;
        pa.chipSelectN = 1'b0;
        pa.writeNotRead = wr;
        pa.mailboxSelect = mb;
        pa.enable = 1'b1;
        pa.data = wr ? d : ~pa.data;
        @(posedge pa.clk) #1;
        pa.chipSelectN = 1'b1;
        pa.enable = 1'b0;
        pa.data = ~pa.data;
        @(negedge pa.clk);
    endtask : aOp
    task automatic bOp(input logic mb);
        @(posedge pb.clk) #1;
        pb.chipSelectN = 1'b0;
        pb.mailboxSelect = mb;
        pb.enable = 1'b1;
        @(posedge pb.clk) #1;
        pb.chipSelectN = 1'b1;
        pb.enable = 1'b0;
        @(negedge pb.clk);
    endtask : bOp
    task automatic cOp(input logic mb, input logic [17:0] d);
        @(posedge pc.clk) #1;
        pc.mailboxSelect = mb;
        pc.enable = 1'b1;
        pc.data = d;
        @(posedge pc.clk) #1;
        pc.enable = 1'b0;
        pc.data = ~pc.data;
        @(negedge pc.clk);
    endtask : cOp
endmodule : tbf_host_model

// ==== tbf_dual_fifo_tb_top.sv ====
// self-checking bench for the triple-port dual fifo
`timescale 1ns/10ps
module tbf_dual_fifo_tb_top;
    localparam int CAP = 8;
    localparam int OFS = 2;
    logic                       mclk;
    logic                       rst_n;
    tbf_pkg::tbf_cfg_type       cfg;
    tbf_pkg::tbf_port_a_in_type pa;
    tbf_pkg::tbf_port_b_in_type pb;
    tbf_pkg::tbf_port_c_in_type pc;
    logic [35:0]                aOut;
    logic [17:0]                bOut;
    // flags: aIR aFF aAF aAE aOR bAE bOR cIR cFF cAF aOe bOe
    logic [11:0]                fl;
    int                         error_cnt;
    int                         check_count;
    logic [31:0]                seed;
    logic [35:0]                q[$];
    tbf_host_model host (.pa(pa), .pb(pb), .pc(pc));
    tbf_dual_fifo #(.CAPACITY(CAP), .OFFSET(OFS)) i_dut (.mclk(mclk), .rst_n(rst_n),
        .cfgIn(cfg), .portAIn(pa), .portADataOut(aOut), .portADataOe(fl[10]),
        .portAInputReady(fl[0]), .portAFullFlag(fl[1]), .portAAlmostFull(fl[2]),
        .portAAlmostEmpty(fl[3]), .portAOutputReady(fl[4]), .portBIn(pb),
        .portBDataOut(bOut), .portBDataOe(fl[11]), .portBAlmostEmpty(fl[5]),
        .portBOutputReady(fl[6]), .portCIn(pc), .portCInputReady(fl[7]),
        .portCFullFlag(fl[8]), .portCAlmostFull(fl[9]));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chkD(string n, logic [35:0] e, logic [35:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask : chkD
    // cross-domain flags get a bounded wait of w mclk cycles
    task automatic chkF(string n, int k, logic e, int w);
        for (int t = 0; t < w && fl[k] !== e; t++) @(negedge mclk);
        check_count++;
        if (fl[k] !== e) begin
            error_cnt++;
            $display("mismatch %s exp %b got %b", n, e, fl[k]);
        end
    endtask : chkF
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        summarize();
    end
    initial begin
        logic [35:0] w;
        logic [35:0] e;
        int np;
        error_cnt = 0;
        check_count = 0;
        seed = 32'h0000FFFB;
        rst_n = 1'b0;
        cfg = '0;
        // pass 0: standard mode, word sizes; pass 1: fall_through_mode mode, byte sizes
        for (int p = 0; p < 2; p++) begin
            @(posedge mclk) #1;
            rst_n = 1'b0;
            cfg = {p[0], p[0], p[0]};
            repeat (3) @(posedge mclk);
            #1 rst_n = 1'b1;
            np = p ? 4 : 2;
            repeat (40) @(posedge mclk);
            chkF("a room", p ? 0 : 1, 1'b1, 0);
            for (int i = 0; i <= CAP; i++) begin
                w = 36'({rnd(), rnd()});
                if (i < CAP) q.push_back(w);
                host.aOp(1'b1, 1'b0, w);
                chkF("a afull", 2, (i + 1 < CAP - OFS), 0);
            end
            chkF("a room", p ? 0 : 1, 1'b0, 0);
            chkF("b aempty", 5, 1'b1, 60);
            chkF("b ready", 6, 1'b1, 0);
            for (int i = 0; i < CAP; i++) begin
                w = q.pop_front();
                for (int k = 0; k < np; k++) begin
                    host.bOp(1'b0);
                    e = p ? {27'h0, w[9*k +: 9]} : {18'h0, w[18*k +: 18]};
                    chkD("b data", e, {18'h0, bOut});
                    if (i == 0 && k == 0) begin
                        repeat (40) @(posedge mclk);
                        chkF("a room", p ? 0 : 1, 1'b0, 0);
                    end
                end
                if (i == 0) chkF("a room", p ? 0 : 1, 1'b1, 40);
                chkF("b aempty", 5, (CAP - 1 - i > OFS), 0);
            end
            chkF("b ready", 6, 1'b0, 0);
            chkF("a afull", 2, 1'b1, 40);
            for (int i = 0; i < CAP; i++) begin
                w = 36'({rnd(), rnd()});
                q.push_back(w);
                for (int k = 0; k < np; k++) begin
                    host.cOp(1'b0, p ? {9'(rnd()), w[9*k +: 9]} : w[18*k +: 18]);
                end
                chkF("c room", p ? 7 : 8, (i + 1 < CAP), 0);
                chkF("c afull", 9, (i + 1 < CAP - OFS), 0);
            end
            chkF("a aempty", 3, 1'b1, 40);
            chkF("a ready", 4, 1'b1, 0);
            for (int i = 0; i < CAP; i++) begin
                host.aOp(1'b0, 1'b0, 36'h0);
                chkD("a data", q.pop_front(), aOut);
                chkF("a aempty", 3, (CAP - 1 - i > OFS), 0);
                if (i == 0) chkF("c room", p ? 7 : 8, 1'b1, 60);
            end
            chkF("c afull", 9, 1'b1, 60);
            chkF("a ready", 4, 1'b0, 0);
            w = 36'({rnd(), rnd()});
            host.aOp(1'b1, 1'b1, w);
            fork
                host.bOp(1'b1);
                chkF("b oe", 11, 1'b1, 40);
            join
            chkF("b oe", 11, 1'b0, 0);
            e = p ? {27'h0, w[8:0]} : {18'h0, w[17:0]};
            chkD("a_to_b_mailbox", e, {18'h0, bOut});
            host.cOp(1'b1, w[35:18]);
            fork
                host.aOp(1'b0, 1'b1, 36'h0);
                chkF("a oe", 10, 1'b1, 40);
            join
            chkF("a oe", 10, 1'b0, 0);
            e = p ? {9'h0, w[26:18], 18'h0} : {w[35:18], 18'h0};
            chkD("c_to_a_mailbox", e, aOut);
        end
        summarize();
    end
endmodule : tbf_dual_fifo_tb_top
